// ==== burst_cfg_pkg.sv ====
// Constants and types of the burst read configuration block.
// Assumes one system clock and pins sampled synchronously to it.
//
// Behaviour
// - Burst starts at first clock with strobe low
// - Initial delay codes 0..7 give 2..9 clocks
// - Delay setting ignored by asynchronous reads
// - Reset gives async mode and default fields
// - Chip deselect leaves register contents alone
// - Register reached only by command sequences
// - Reads always allowed; writes dropped while busy
// - Sixteen bits on low lines, upper zero
// - Read command latches bank; other bank array
// - Top bit zero sync burst, one async
// - Data held one clock per word
// - Timing bit moves indicator one beat earlier
// - Linear burst order only
// - Bursts and data on rising edge
// - Length codes 1..3 burst, others async
// - Default delay code seven, nine clocks
// - Indicator driven only with outputs enabled
// - Reset ends burst, floats bus, restores defaults
package burst_cfg_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W   = 19;  // Double word address.
    localparam int DATA_W   = 32;  // Data bus width.
    localparam int CFG_W    = 16;  // Register width.
    localparam int BANK_BIT = 18;  // Bank select address bit.
    localparam int CMD_AW   = 11;  // Address bits checked by commands.

    // ----------------------------------------
    // Register layout and reset value
    // ----------------------------------------
    typedef struct packed {
        logic       read_mode_sel;         // 0 sync burst, 1 async.
        logic       rsvd_14;               // Reserved.
        logic [3:0] initial_delay_cfg;     // Code plus two clocks.
        logic       data_hold_cfg;         // 0 hold one clock.
        logic       indicator_timing_cfg;  // 1 indicator one beat early.
        logic       burst_order_cfg;       // 1 linear.
        logic       clock_edge_cfg;        // 1 rising edge.
        logic [2:0] rsvd_5_3;              // Reserved.
        logic [2:0] burst_length_cfg;      // Burst length code.
    } cfg_t;

    localparam logic [15:0] CFG_RESET = 16'h9cc3;  // Async, delay 7, len 8.

    // ----------------------------------------
    // Burst encodings and timing
    // ----------------------------------------
    localparam logic [2:0] BL_TWO   = 3'h1;  // Two double words.
    localparam logic [2:0] BL_FOUR  = 3'h2;  // Four double words.
    localparam logic [2:0] BL_EIGHT = 3'h3;  // Eight double words.
    localparam logic [4:0] DLY_LOAD = 5'h01; // Code plus this is delay less one.

    // ----------------------------------------
    // Command sequence codes
    // ----------------------------------------
    localparam logic [10:0] UNLOCK1_A  = 11'h555;
    localparam logic [10:0] UNLOCK2_A  = 11'h2aa;
    localparam logic [7:0]  UNLOCK1_D  = 8'haa;
    localparam logic [7:0]  UNLOCK2_D  = 8'h55;
    localparam logic [7:0]  CMD_CFG_RD = 8'hc6;  // Enter register read.
    localparam logic [7:0]  CMD_CFG_WR = 8'hd0;  // Register write setup.
    localparam logic [7:0]  CMD_EXIT   = 8'hf0;  // Back to array reads.

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bus_wr_t;

    typedef struct packed {
        logic        cfg_wr;   // Register write request.
        logic [15:0] cfg_data; // Value to write.
        logic        rd_enter; // Enter register read mode.
        logic        rd_bank;  // Bank latched with it.
        logic        rd_exit;  // Leave register read mode.
    } cmd_evt_t;

endpackage

// ==== burst_read_config_register.sv ====
// Burst read and configuration register logic of the flash.
// Assumes pins are synchronous to clk_sys and the array read
// port answers combinationally for the address it is given.
`timescale 1ns/1ps
module burst_read_config_register (
    input  wire logic                             clk_sys,
    input  wire logic                             rst_n,
    input  wire logic                             ce_n,
    input  wire logic                             oe_n,
    input  wire logic                             we_n,
    input  wire logic                             addr_valid_n,
    input  wire logic [burst_cfg_pkg::ADDR_W-1:0] addr,
    input  wire logic [burst_cfg_pkg::DATA_W-1:0] dq_in,
    output      logic [burst_cfg_pkg::DATA_W-1:0] dq_out,
    output      logic                             dq_oe_n,
    output      logic                             burst_end_ind_n,
    output      logic                             burst_end_ind_oe_n,
    input  wire logic                             algo_busy,
    output      logic [burst_cfg_pkg::ADDR_W-1:0] array_addr,
    input  wire logic [burst_cfg_pkg::DATA_W-1:0] array_data
);
    import burst_cfg_pkg::*;

    // ----------------------------------------
    // Types
    // ----------------------------------------

    // Burst sequencer states.
    typedef enum logic [1:0] {
        S_IDLE,
        S_DELAY,
        S_DATA
    } bst_t;

    // Whole state of the block.
    typedef struct packed {
        cfg_t              cfg;       // Live register.
        cfg_t              act;       // Settings of the running burst.
        bst_t              st;        // Sequencer state.
        logic [4:0]        cnt;       // Initial delay countdown.
        logic [2:0]        beat;      // Beat of the next fetch.
        logic [ADDR_W-1:0] base;      // Latched start address.
        logic [ADDR_W-1:0] fa;        // Array fetch address.
        logic              we_prev;   // Write enable last cycle.
        logic              adv_prev;  // Address strobe last cycle.
        logic              crd_mode;  // Register read mode on.
        logic              crd_bank;  // Bank that reads the register.
        logic [DATA_W-1:0] dq;        // Output data.
        logic              drive;     // Output data is valid.
        logic              ind;       // End of burst active.
    } state_t;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    state_t            s_q;        // Registered state.
    state_t            s_d;        // Next state.
    bus_wr_t           wr;         // Captured write cycle.
    logic              wr_stb;     // Write cycle completes.
    cmd_evt_t          evt;        // Decoded command events.
    logic              start;      // Burst start seen.
    logic              burst_en;   // Register allows bursts.
    logic              cfg_hit;    // Start address reads register.
    logic              fa_hit;     // Fetch address reads register.
    logic [2:0]        mask_new;   // Beat mask from live register.
    logic [2:0]        mask_act;   // Beat mask of running burst.
    logic [2:0]        ind_beat;   // Beat that raises the indicator.
    logic [2:0]        beat_nx;    // Beat after the one presented.
    logic [ADDR_W-1:0] addr_nx;    // Fetch address of beat_nx.
    logic              selected;   // Chip selected.

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Beat mask of a length code; zero means no burst.
    function automatic logic [2:0] len_mask(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        unique case (code)
            BL_TWO:   m = 3'h1;
            BL_FOUR:  m = 3'h3;
            BL_EIGHT: m = 3'h7;
            default:  m = 3'h0;
        endcase
        return m;
    endfunction

    // ----------------------------------------
    // Write cycle capture and command decode
    // ----------------------------------------

    // A write completes on the rising edge of write enable
    // while the chip stays selected.
    assign wr_stb  = we_n & ~s_q.we_prev & ~ce_n;
    assign wr      = {addr, dq_in};

    // The register has no array address; only the command
    // sequences reach it.
    cmd_seq_decoder u_dec (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_stb  (wr_stb),
        .wr      (wr),
        .evt     (evt)
    );

    // ----------------------------------------
    // Burst decode
    // ----------------------------------------

    assign selected = ~ce_n;

    // Start on the first clock that sees the strobe low. A rising
    // strobe edge cannot come first when the strobe is sampled on
    // the clock, so the clocked start covers both cases.
    assign start = selected & we_n & ~addr_valid_n & s_q.adv_prev;

    // Top bit zero and a valid length enable bursts.
    assign mask_new = len_mask(s_q.cfg.burst_length_cfg);
    assign burst_en = ~s_q.cfg.read_mode_sel & (mask_new != 3'h0);

    // Register reads come from the latched bank only.
    assign cfg_hit = s_q.crd_mode & (addr[BANK_BIT] == s_q.crd_bank);
    assign fa_hit  = s_q.crd_mode & (s_q.fa[BANK_BIT] == s_q.crd_bank);

    // Indicator beat: last, or one earlier with the timing bit.
    assign mask_act = len_mask(s_q.act.burst_length_cfg);
    assign ind_beat = mask_act - {2'b00, s_q.act.indicator_timing_cfg};

    // Next beat wraps inside the burst group.
    assign beat_nx = (s_q.beat + 3'h1) & mask_act;

    wrap_addr_gen u_wrap (
        .base (s_q.base),
        .beat (beat_nx),
        .mask (mask_act),
        .addr (addr_nx)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------

    // One process builds the whole next state.
    always_comb begin
        s_d          = s_q;
        s_d.we_prev  = we_n;
        s_d.adv_prev = addr_valid_n;

        // Register write; dropped while an algorithm runs. The
        // deselect path clears only the burst state, so contents
        // survive a deselect.
        if (evt.cfg_wr && !algo_busy) begin
            s_d.cfg = cfg_t'(evt.cfg_data);
        end

        // Register read mode enter and exit.
        if (evt.rd_enter) begin
            s_d.crd_mode = 1'b1;
            s_d.crd_bank = evt.rd_bank;
        end else if (evt.rd_exit) begin
            s_d.crd_mode = 1'b0;
        end

        unique case (s_q.st)
            S_IDLE: begin
                // Asynchronous reads follow the pins; the delay
                // field plays no part here.
                s_d.fa    = addr;
                s_d.drive = selected & we_n;
                s_d.ind   = 1'b0;
                // Register reads sit on the low lines, upper zero.
                if (fa_hit) begin
                    s_d.dq = {16'h0000, s_q.cfg};
                end else begin
                    s_d.dq = array_data;
                end
                // Register reads stay single-cycle in burst mode.
                if (start && burst_en && !cfg_hit) begin
                    // Snapshot so later writes wait for the
                    // next burst.
                    s_d.act   = s_q.cfg;
                    s_d.base  = addr;
                    s_d.fa    = addr;
                    s_d.beat  = 3'h0;
                    s_d.drive = 1'b0;
                    // Delay less one: code 0..7 gives 2..9.
                    s_d.cnt   = {1'b0, s_q.cfg.initial_delay_cfg} + DLY_LOAD;
                    s_d.st    = S_DELAY;
                end
            end

            S_DELAY: begin
                s_d.cnt = s_q.cnt - 5'h01;
                // First data lands so the host samples it on the
                // delay-th edge after the start edge.
                if (s_q.cnt == 5'h01) begin
                    s_d.dq    = array_data;
                    s_d.drive = 1'b1;
                    s_d.ind   = (s_q.beat == ind_beat);
                    s_d.beat  = beat_nx;
                    s_d.fa    = addr_nx;
                    s_d.st    = S_DATA;
                end
            end

            S_DATA: begin
                // Each word holds exactly one clock; the reserved
                // hold code acts as the default.
                s_d.dq   = array_data;
                s_d.ind  = (s_q.beat == ind_beat);
                s_d.beat = beat_nx;
                s_d.fa   = addr_nx;
            end

            default: begin
                s_d.st = S_IDLE;
            end
        endcase

        // A new strobe mid-burst drops the old burst and starts
        // over at the new address.
        if (s_q.st != S_IDLE && start) begin
            s_d.act   = s_q.cfg;
            s_d.base  = addr;
            s_d.fa    = addr;
            s_d.beat  = 3'h0;
            s_d.drive = 1'b0;
            s_d.ind   = 1'b0;
            s_d.cnt   = {1'b0, s_q.cfg.initial_delay_cfg} + DLY_LOAD;
            s_d.st    = (burst_en && !cfg_hit) ? S_DELAY : S_IDLE;
        end

        // Deselect or a write cycle ends the burst at once.
        if (!selected || !we_n) begin
            s_d.st    = S_IDLE;
            s_d.drive = 1'b0;
            s_d.ind   = 1'b0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------

    // Reset ends any burst, floats the bus, selects async reads
    // and loads the register defaults.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q          <= '0;
            s_q.cfg      <= cfg_t'(CFG_RESET);
            s_q.act      <= cfg_t'(CFG_RESET);
            s_q.st       <= S_IDLE;
            s_q.we_prev  <= 1'b1;
            s_q.adv_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // Data and fetch address come straight from flip-flops.
    assign dq_out     = s_q.dq;
    assign array_addr = s_q.fa;

    // The bus floats unless selected, output enabled and data
    // is valid; output enable never stalls the burst itself.
    assign dq_oe_n = ~(s_q.drive & ~oe_n & selected);

    // The indicator is driven only while output enable is low,
    // high until it drops for its one beat.
    assign burst_end_ind_oe_n = ~(~oe_n & selected);
    assign burst_end_ind_n    = ~s_q.ind;

endmodule

// ==== burst_read_config_register_bench.sv ====
// Self-checking bench of the burst configuration block.
// Assumes the host model drives the bus and an array image answers at once.
`timescale 1ns/1ps
module burst_read_config_register_bench;
    import burst_cfg_pkg::*;
    logic              clk_sys, rst_n, algo_busy, ce_n, oe_n, we_n, addr_valid_n, take;
    logic              dq_oe_n, burst_end_ind_n, burst_end_ind_oe_n;
    logic [ADDR_W-1:0] addr, array_addr, a;
    logic [DATA_W-1:0] dq_in, dq_out, array_data;
    logic [33:0]       exp_q[$];
    logic [15:0]       v;
    logic [15:0]       dis[5] = '{16'h08c0, 16'h08c4, 16'h08c5, 16'h08c6, 16'h88c3};
    logic [3:0]        dly;
    logic [2:0]        m;
    int                miscompares = 0, n_checks = 0, seed = 68977, r, len;

    // Array image: each word carries its own address, so order errors show.
    function automatic logic [DATA_W-1:0] word(input logic [ADDR_W-1:0] x);
        return {x[12:0], x};
    endfunction
    assign array_data = word(array_addr);

    burst_read_config_register dut (.clk_sys, .rst_n, .ce_n, .oe_n, .we_n, .addr_valid_n,
        .addr, .dq_in, .dq_out, .dq_oe_n, .burst_end_ind_n, .burst_end_ind_oe_n,
        .algo_busy, .array_addr, .array_data);
    bus_host_model host (.clk_sys, .ce_n, .oe_n, .we_n, .addr_valid_n, .addr, .dq_in, .take);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic cmp(input string what, input logic [33:0] e, input logic [33:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    // Watcher: every beat the host takes is matched with the oldest note.
    always @(posedge clk_sys) begin
        if (take === 1'b1) begin
            cmp("read beat", (exp_q.size() > 0) ? exp_q.pop_front() : 34'hx, {dq_oe_n, burst_end_ind_n, dq_out});
        end
    end

    // Register readback through the read command, then back to the array.
    task automatic check_cfg(input logic [15:0] e, input logic bank);
        host.seq(CMD_CFG_RD, {bank, 18'h00123}, 16'h0000);
        exp_q.push_back({2'b01, 16'h0000, e});
        host.rd({bank, 18'h2a5a5});
        host.wr('0, {24'h0, CMD_EXIT});
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        algo_busy = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        // After reset: array read with two-clock latency, then the register.
        exp_q.push_back({2'b01, word(19'h40155)});
        host.rd(19'h40155);
        host.seq(CMD_CFG_RD, 19'h40000, 16'h0000);
        exp_q.push_back({2'b01, 32'h0000_9cc3});
        host.rd(19'h40155);
        exp_q.push_back({2'b01, word(19'h00155)});
        host.rd(19'h00155);
        host.wr('0, {24'h0, CMD_EXIT});
        // Every length, both indicator timings, shortest and longest delay.
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            dly = (i < 2) ? 4'(i * 7) : 4'(r[2:0]);
            len = 2 << (i % 3);
            m = 3'(len - 1);
            v = {2'b00, dly, 1'b0, r[3], 2'b11, 3'b000, 3'(i % 3 + 1)};
            host.seq(CMD_CFG_WR, r[30:12], v);
            check_cfg(v, r[5]);
            a = 19'($random(seed));
            for (int k = 0; k < 2 * len; k++) begin
                exp_q.push_back({1'b0, (k % len) != (len - 1 - r[3]),
                    word({a[18:3], (a[2:0] & ~m) | ((a[2:0] + 3'(k)) & m)})});
            end
            host.burst(a, dly + 2, 2 * len);
        end
        // A write during a running algorithm is dropped; deselects kept it too.
        algo_busy <= 1'b1;
        host.seq(CMD_CFG_WR, '0, 16'h9cc1);
        @(posedge clk_sys);
        algo_busy <= 1'b0;
        check_cfg(v, 1'b1);
        // Disabled lengths and the async bit: strobe ignored, plain reads.
        foreach (dis[j]) begin
            host.seq(CMD_CFG_WR, '0, dis[j]);
            a = 19'($random(seed));
            exp_q.push_back({2'b01, word(a)});
            host.rd(a);
        end
        // Reset in mid-burst floats the bus and restores the defaults.
        host.seq(CMD_CFG_WR, '0, 16'h04c3);
        host.kick(19'h00010);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b0;
        #1 cmp("reset outputs", {2'b11, 32'h0}, {dq_oe_n, burst_end_ind_n, dq_out});
        cmp("indicator enable", 34'h0, {33'h0, burst_end_ind_oe_n});
        @(posedge clk_sys);
        rst_n <= 1'b1;
        check_cfg(16'h9cc3, 1'b0);
        repeat (4) @(posedge clk_sys);
        cmp("notes left", 34'h0, 34'(exp_q.size()));
        complete_run();
    end
endmodule

// ==== burst_read_config_register_sva.sv ====
// Checker of the burst configuration block, on its top ports only.
// Assumes one clock domain; bound into the design after the module.
`timescale 1ns/1ps
module burst_read_config_register_sva (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        ce_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic        addr_valid_n,
    input wire logic [18:0] addr,
    input wire logic [31:0] dq_out,
    input wire logic        dq_oe_n,
    input wire logic        burst_end_ind_n,
    input wire logic        burst_end_ind_oe_n,
    input wire logic [18:0] array_addr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // A burst starts at the first edge that sees the strobe low.
    sequence s_start;
        !ce_n && we_n && !addr_valid_n && $past(addr_valid_n);
    endsequence

    property p_ind_oe; burst_end_ind_oe_n == (oe_n || ce_n); endproperty
    a_ind_oe: assert property (p_ind_oe)
        else $error("indicator enable does not follow oe_n and ce_n");
    property p_dq_oe; !dq_oe_n |-> !oe_n && !ce_n; endproperty
    a_dq_oe: assert property (p_dq_oe)
        else $error("data bus driven without select and output enable");
    property p_rst_data; $rose(rst_n) |-> dq_out == '0 && array_addr == '0; endproperty
    a_rst_data: assert property (p_rst_data)
        else $error("data or fetch address not cleared by reset");
    property p_rst_ind; $rose(rst_n) |-> burst_end_ind_n; endproperty
    a_rst_ind: assert property (p_rst_ind)
        else $error("indicator active straight after reset");
    // The indicator marks one beat only, since each word stands one clock.
    property p_ind_pulse; $fell(burst_end_ind_n) |=> burst_end_ind_n; endproperty
    a_ind_pulse: assert property (p_ind_pulse)
        else $error("indicator low for more than one clock");
    property p_start_latch; s_start |=> array_addr == $past(addr); endproperty
    a_start_latch: assert property (p_start_latch)
        else $error("start address not latched at the strobe edge");
    property p_ind_on_data; !burst_end_ind_n && !oe_n && !ce_n |-> !dq_oe_n; endproperty
    a_ind_on_data: assert property (p_ind_on_data)
        else $error("indicator low outside a data beat");
    property p_start_quiet; s_start |=> burst_end_ind_n; endproperty
    a_start_quiet: assert property (p_start_quiet)
        else $error("indicator low in the first delay clock");

    c_start: cover property (s_start);
    c_ind: cover property ($fell(burst_end_ind_n));
    c_rst: cover property ($rose(rst_n));
endmodule

bind burst_read_config_register burst_read_config_register_sva u_sva (
    .clk_sys, .rst_n, .ce_n, .oe_n, .we_n, .addr_valid_n, .addr, .dq_out,
    .dq_oe_n, .burst_end_ind_n, .burst_end_ind_oe_n, .array_addr
);

// ==== bus_host_model.sv ====
// Host controller model: write cycles, command sequences, reads, bursts.
// Assumes the bench calls one task at a time and samples while take is high.
`timescale 1ns/1ps
module bus_host_model (
    input  wire logic                             clk_sys,
    output      logic                             ce_n,
    output      logic                             oe_n,
    output      logic                             we_n,
    output      logic                             addr_valid_n,
    output      logic [burst_cfg_pkg::ADDR_W-1:0] addr,
    output      logic [burst_cfg_pkg::DATA_W-1:0] dq_in,
    output      logic                             take
);
    import burst_cfg_pkg::*;

    // Idle levels: selected, outputs off, no strobe.
    initial begin
        ce_n = 1'b0;
        oe_n = 1'b1;
        we_n = 1'b1;
        addr_valid_n = 1'b1;
        addr = '0;
        dq_in = '0;
        take = 1'b0;
    end

    // One write; data is inverted once taken so a stale value never lingers.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        we_n <= 1'b0;
        addr <= a;
        dq_in <= d;
        @(posedge clk_sys);
        we_n <= 1'b1;
        @(posedge clk_sys);
        dq_in <= ~d;
    endtask

    // Two unlock cycles, the command, then bank or value.
    task automatic seq(input logic [7:0] c, input logic [ADDR_W-1:0] a, input logic [15:0] v);
        wr({8'h00, UNLOCK1_A}, {24'h0, UNLOCK1_D});
        wr({8'h00, UNLOCK2_A}, {24'h0, UNLOCK2_D});
        wr({8'h00, UNLOCK1_A}, {24'h0, c});
        wr(a, {16'h0, v});
    endtask

    // Strobe held low for exactly one edge, outputs enabled.
    task automatic kick(input logic [ADDR_W-1:0] a);
        @(posedge clk_sys);
        addr_valid_n <= 1'b0;
        addr <= a;
        oe_n <= 1'b0;
        @(posedge clk_sys);
        addr_valid_n <= 1'b1;
    endtask

    // Single read: the word is sampled at the third edge after the address.
    task automatic rd(input logic [ADDR_W-1:0] a);
        kick(a);
        @(posedge clk_sys);
        take <= 1'b1;
        @(posedge clk_sys);
        take <= 1'b0;
        oe_n <= 1'b1;
    endtask

    // Burst: n clocks of delay, cnt beats taken, then deselect to end it.
    task automatic burst(input logic [ADDR_W-1:0] a, input int n, input int cnt);
        kick(a);
        repeat (n - 1) @(posedge clk_sys);
        take <= 1'b1;
        repeat (cnt) @(posedge clk_sys);
        take <= 1'b0;
        oe_n <= 1'b1;
        ce_n <= 1'b1;
        @(posedge clk_sys);
        ce_n <= 1'b0;
    endtask
endmodule

// ==== cmd_seq_decoder.sv ====
// Decodes the four-cycle configuration command sequences.
// Assumes one write strobe per completed bus write cycle.
`timescale 1ns/1ps
module cmd_seq_decoder (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  wr_stb,
    input  wire burst_cfg_pkg::bus_wr_t wr,
    output      burst_cfg_pkg::cmd_evt_t evt
);
    import burst_cfg_pkg::*;

    typedef struct packed {
        logic [1:0] step;  // Cycles matched so far.
        logic       rd;    // Sequence is a register read.
        cmd_evt_t   evt;   // One-cycle events.
    } dec_t;

    dec_t s_q;
    dec_t s_d;
    logic [CMD_AW-1:0] a;
    logic [7:0]        d;

    assign a   = wr.addr[CMD_AW-1:0];
    assign d   = wr.data[7:0];
    assign evt = s_q.evt;

    // Walk the unlock cycles, then the command and final cycle.
    always_comb begin
        s_d     = s_q;
        s_d.evt = '0;
        if (wr_stb) begin
            if (s_q.step != 2'd3 && d == CMD_EXIT) begin
                s_d.step        = 2'd0;
                s_d.evt.rd_exit = 1'b1;
            end else begin
                unique case (s_q.step)
                    2'd0: begin
                        s_d.step = (a == UNLOCK1_A && d == UNLOCK1_D) ? 2'd1 : 2'd0;
                    end
                    2'd1: begin
                        s_d.step = (a == UNLOCK2_A && d == UNLOCK2_D) ? 2'd2 : 2'd0;
                    end
                    2'd2: begin
                        s_d.rd   = (d == CMD_CFG_RD);
                        s_d.step = (a == UNLOCK1_A && (d == CMD_CFG_RD || d == CMD_CFG_WR)) ? 2'd3 : 2'd0;
                    end
                    2'd3: begin
                        // Fourth cycle: bank address or register value.
                        s_d.step = 2'd0;
                        if (s_q.rd) begin
                            s_d.evt.rd_enter = 1'b1;
                            s_d.evt.rd_bank  = wr.addr[BANK_BIT];
                        end else begin
                            s_d.evt.cfg_wr   = 1'b1;
                            s_d.evt.cfg_data = wr.data[15:0];
                        end
                    end
                endcase
            end
        end
    end

    // Register the decoder state.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ==== wrap_addr_gen.sv ====
// Linear wrapping address of one burst beat.
// Assumes mask is length minus one of a power-of-two burst.
`timescale 1ns/1ps
module wrap_addr_gen (
    input  wire logic [burst_cfg_pkg::ADDR_W-1:0] base,
    input  wire logic [2:0]                       beat,
    input  wire logic [2:0]                       mask,
    output      logic [burst_cfg_pkg::ADDR_W-1:0] addr
);
    import burst_cfg_pkg::*;

    logic [2:0] low;

    // Low bits advance and wrap inside the aligned group.
    assign low  = ((base[2:0] + beat) & mask) | (base[2:0] & ~mask);
    assign addr = {base[ADDR_W-1:3], low};
endmodule
